// ---- design/osm_pkg.sv ----
// Purpose: shared constants and types for the one-bit stream monitor
// Assumes: 8-bit register port, 20 MHz system clock
// Notes: attenuation is counted in 1/8 dB steps
package osm_pkg;
   // register map
   localparam logic [7:0] OSM_ADDR_CTRL = 8'h09;
   localparam logic [7:0] OSM_ADDR_STATUS = 8'h0a;
   localparam logic [7:0] OSM_ADDR_MASK = 8'h0b;
   localparam logic [7:0] OSM_ADDR_CFG = 8'h0c;
   // control register fields
   localparam int OSM_CTRL_STATIC = 3;
   localparam int OSM_CTRL_INVALID = 2;
   localparam int OSM_CTRL_PM_SEL = 1;
   localparam int OSM_CTRL_PM_EN = 0;
   localparam logic [7:0] OSM_CTRL_RESET = 8'h08;
   localparam logic [7:0] OSM_CTRL_USED = 8'h0f;
   // configuration register fields
   localparam int OSM_CFG_SOFT = 0;
   localparam int OSM_CFG_POL = 1;
   localparam int OSM_CFG_FAST = 2;
   localparam logic [7:0] OSM_CFG_RESET = 8'h01;
   localparam logic [7:0] OSM_CFG_USED = 8'h07;
   // status and mask fields
   localparam int OSM_ST_STATIC = 0;
   localparam int OSM_ST_INVALID = 1;
   localparam int OSM_ST_MUTED = 2;
   localparam logic [7:0] OSM_ST_USED = 8'h07;
   localparam logic [7:0] OSM_ZERO8 = 8'h00;
   // pattern detection
   localparam int OSM_WIN_LEN = 28;
   localparam logic [4:0] OSM_RUN_LEN = 5'd28;
   localparam logic [4:0] OSM_INVALID_MAX = 5'd24;
   localparam logic [4:0] OSM_INVALID_MIN = 5'(OSM_WIN_LEN - 24);
   // level ramp
   localparam int OSM_ATTN_W = 10;
   localparam logic [9:0] OSM_ATTN_ZERO = 10'h000;
   localparam logic [9:0] OSM_ATTN_MUTE = 10'h3ff;
   localparam logic [9:0] OSM_ATTN_INVALID = 10'h030;
   localparam logic [9:0] OSM_ATTN_ONE = 10'h001;
   localparam int OSM_STEPS_PER_DB = 8;
   localparam int OSM_DB_PERIODS_SLOW = 512;
   localparam int OSM_DB_PERIODS_FAST = 1024;
   localparam logic [7:0] OSM_STEP_SLOW = 8'(OSM_DB_PERIODS_SLOW / OSM_STEPS_PER_DB);
   localparam logic [7:0] OSM_STEP_FAST = 8'(OSM_DB_PERIODS_FAST / OSM_STEPS_PER_DB);
   localparam logic [7:0] OSM_ONE8 = 8'h01;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } osm_bus_s;

   typedef struct packed {
      logic valid;
      logic value;
   } osm_bit_s;

   typedef struct packed {
      logic static_run;
      logic invalid;
   } osm_hits_s;

   typedef enum logic [1:0] {
      OSM_RAMP_IDLE = 2'b00,
      OSM_RAMP_STEP = 2'b01,
      OSM_RAMP_HOLD = 2'b11
   } osm_ramp_e;
endpackage : osm_pkg

// ---- design/osm_sync.sv ----
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clock_i
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module osm_sync #(
   parameter int W = 2
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // pins in, clean levels out
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clock_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               stage1[g] <= 1'b0;
               stage2[g] <= 1'b0;
               stage3[g] <= 1'b0;
               level_o[g] <= 1'b0;
            end else begin
               stage1[g] <= pin_i[g];
               stage2[g] <= stage1[g];
               stage3[g] <= stage2[g];
               // stage1 stays private to stage2
               if (stage2[g] == stage3[g]) begin
                  level_o[g] <= stage3[g];
               end
            end
         end
      end
   endgenerate
endmodule : osm_sync

// ---- design/osm_detect.sv ----
// Purpose: static-run and near-static window detector
// Assumes: one valid pulse per received stream bit
// Notes: hits are held until the pattern breaks or clear is raised
`timescale 1ns/1ps
module osm_detect
   import osm_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // received bits
   input wire logic clear_i,
   input wire osm_bit_s bit_i,
   // pattern flags
   output osm_hits_s hits_o
);
   logic [OSM_WIN_LEN-1:0] window;
   logic [4:0] fill;
   logic [4:0] ones;
   logic [4:0] run;
   logic [4:0] next_ones;
   logic [4:0] next_run;
   logic next_full;

   always_comb begin
      next_ones = ones + 5'(bit_i.value) - 5'(window[OSM_WIN_LEN-1] & (fill == OSM_RUN_LEN));
      next_full = (fill == OSM_RUN_LEN) || (fill == OSM_RUN_LEN - 5'd1);
      if (fill != 5'd0 && bit_i.value == window[0]) begin
         next_run = (run == OSM_RUN_LEN) ? run : run + 5'd1;
      end else begin
         next_run = 5'd1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         window <= '0;
         fill <= 5'd0;
         ones <= 5'd0;
         run <= 5'd0;
         hits_o <= '0;
      end else if (clear_i) begin
         window <= '0;
         fill <= 5'd0;
         ones <= 5'd0;
         run <= 5'd0;
         hits_o <= '0;
      end else if (bit_i.valid) begin
         window <= {window[OSM_WIN_LEN-2:0], bit_i.value};
         fill <= (fill == OSM_RUN_LEN) ? fill : fill + 5'd1;
         ones <= next_ones;
         run <= next_run;
         hits_o.static_run <= (next_run == OSM_RUN_LEN);
         // more than 24 of 28 alike, either polarity
         hits_o.invalid <= next_full &&
            ((next_ones > OSM_INVALID_MAX) || (next_ones < OSM_INVALID_MIN));
      end
   end
endmodule : osm_detect

// ---- design/osm_monitor.sv ----
// Purpose: one-bit stream input monitor with phase-modulated reception
// Assumes: bit clock well below a quarter of clock_i, register port as in osm_pkg
// Notes: attenuation and mute stepping run on recovered bit-clock edges
//
// Notes on behaviour
// - with static detect enabled, 28 identical bits in a row request a mute.
// - static detect enable resets to one and clearing it stops that detection.
// - once a static mute has reached full attenuation the mute outputs go active at the set polarity.
// - with invalid detect enabled, over 24 alike of 28 bits attenuates; it resets off.
// - an invalid detection drives the mute outputs active at the set polarity.
// - phase mode enable set to one switches reception to phase-modulated decoding.
// - phase mode enable resets to zero, giving normal reception.
// - soft ramp steps 1/8 dB, 1 dB per 512 bit clocks or 1024 at the 128x clock.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module osm_monitor
   import osm_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // register port
   input wire osm_bus_s bus_i,
   output logic [7:0] rdata_o,
   // stream link pins
   input wire logic stream_bit_clock_i,
   input wire logic one_bit_stream_i,
   // recovered stream toward the converter path
   output osm_bit_s stream_o,
   // level path
   output logic [OSM_ATTN_W-1:0] attn_o,
   output logic mute_req_o,
   output logic [1:0] mute_control_out_o,
   // mode outputs
   output logic phase_mod_enable_o,
   output logic phase_mod_clock_select_o,
   // interrupt
   output logic irq_o
);
   logic [7:0] ctrl;
   logic [7:0] cfg;
   logic [7:0] status;
   logic [7:0] mask;
   logic [1:0] pins;
   logic sclk;
   logic sdata;
   logic sclk_d;
   logic rise;
   logic fall;
   logic pm_phase;
   logic first_half;
   osm_bit_s rx_bit;
   osm_hits_s hits;
   osm_hits_s hits_d;
   logic static_en;
   logic invalid_en;
   logic pm_en;
   logic pm_sel;
   logic soft_en;
   logic mute_pol;
   logic fast_clk;
   logic detect_clear;
   logic [OSM_ATTN_W-1:0] attn;
   logic [OSM_ATTN_W-1:0] target;
   logic [7:0] step_cnt;
   logic [7:0] step_len;
   logic step_tick;
   osm_ramp_e ramp_state;
   osm_ramp_e next_ramp_state;
   logic muted;
   logic muted_d;
   logic mute_active;
   logic [7:0] ev;
   logic rd_status;

   // register fields
   assign static_en = ctrl[OSM_CTRL_STATIC];
   assign invalid_en = ctrl[OSM_CTRL_INVALID];
   assign pm_sel = ctrl[OSM_CTRL_PM_SEL];
   assign pm_en = ctrl[OSM_CTRL_PM_EN];
   assign soft_en = cfg[OSM_CFG_SOFT];
   assign mute_pol = cfg[OSM_CFG_POL];
   assign fast_clk = cfg[OSM_CFG_FAST];

   // control register: reset leaves static detect on, the rest off
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl <= OSM_CTRL_RESET;
      end else if (bus_i.wr && bus_i.addr == OSM_ADDR_CTRL) begin
         ctrl <= bus_i.wdata & OSM_CTRL_USED;
      end
   end

   // configuration register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg <= OSM_CFG_RESET;
      end else if (bus_i.wr && bus_i.addr == OSM_ADDR_CFG) begin
         cfg <= bus_i.wdata & OSM_CFG_USED;
      end
   end

   // interrupt mask register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mask <= OSM_ZERO8;
      end else if (bus_i.wr && bus_i.addr == OSM_ADDR_MASK) begin
         mask <= bus_i.wdata & OSM_ST_USED;
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= OSM_ZERO8;
      end else if (bus_i.rd) begin
         case (bus_i.addr)
            OSM_ADDR_CTRL: rdata_o <= ctrl;
            OSM_ADDR_CFG: rdata_o <= cfg;
            OSM_ADDR_MASK: rdata_o <= mask;
            OSM_ADDR_STATUS: rdata_o <= status;
            default: rdata_o <= OSM_ZERO8;
         endcase
      end else begin
         rdata_o <= OSM_ZERO8;
      end
   end

   // link pins into the system clock
   osm_sync #(
      .W(2)
   ) u_sync (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .pin_i({stream_bit_clock_i, one_bit_stream_i}),
      .level_o(pins)
   );
   assign sclk = pins[1];
   assign sdata = pins[0];

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_d <= 1'b0;
      end else begin
         sclk_d <= sclk;
      end
   end
   assign rise = sclk & ~sclk_d;
   assign fall = ~sclk & sclk_d;

   // bit recovery
   // normal: data taken on each rising edge
   // phase mode, fast clock: a bit spans two clock periods, first half is true data
   // phase mode, slow clock: one bit per period, true half ends on the falling edge
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pm_phase <= 1'b0;
         first_half <= 1'b0;
         rx_bit <= '0;
      end else begin
         rx_bit.valid <= 1'b0;
         if (!pm_en) begin
            pm_phase <= 1'b0;
            if (rise) begin
               rx_bit.valid <= 1'b1;
               rx_bit.value <= sdata;
            end
         end else if (!pm_sel) begin
            // 128Fs supplied: every second rising edge closes a bit
            if (rise) begin
               pm_phase <= ~pm_phase;
               if (!pm_phase) begin
                  first_half <= sdata;
               end else begin
                  rx_bit.valid <= 1'b1;
                  rx_bit.value <= first_half;
               end
            end
         end else begin
            // 64Fs supplied: sample at the falling edge
            if (fall) begin
               rx_bit.valid <= 1'b1;
               rx_bit.value <= sdata;
            end
         end
      end
   end

   // recovered stream passes straight through
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stream_o <= '0;
      end else begin
         stream_o <= rx_bit;
      end
   end

   // a mode change restarts pattern history to avoid false hits
   assign detect_clear = bus_i.wr && bus_i.addr == OSM_ADDR_CTRL &&
      bus_i.wdata[OSM_CTRL_PM_SEL:OSM_CTRL_PM_EN] != {pm_sel, pm_en};

   osm_detect u_detect (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .clear_i(detect_clear),
      .bit_i(rx_bit),
      .hits_o(hits)
   );

   // target level, static mute outranks invalid attenuation
   always_comb begin
      if (static_en && hits.static_run) begin
         target = OSM_ATTN_MUTE;
      end else if (invalid_en && hits.invalid) begin
         target = OSM_ATTN_INVALID;
      end else begin
         target = OSM_ATTN_ZERO;
      end
   end

   // ramp pacing counted in bit-clock periods
   assign step_len = fast_clk ? OSM_STEP_FAST : OSM_STEP_SLOW;
   assign step_tick = rise && (step_cnt == step_len - OSM_ONE8);

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         step_cnt <= OSM_ZERO8;
      end else if (ramp_state != OSM_RAMP_STEP) begin
         step_cnt <= OSM_ZERO8;
      end else if (rise) begin
         step_cnt <= step_tick ? OSM_ZERO8 : step_cnt + OSM_ONE8;
      end
   end

   always_comb begin
      case (ramp_state)
         OSM_RAMP_IDLE: begin
            next_ramp_state = (target != attn) ? OSM_RAMP_STEP : OSM_RAMP_IDLE;
         end
         OSM_RAMP_STEP: begin
            if (target == attn) begin
               next_ramp_state = (attn == OSM_ATTN_ZERO) ? OSM_RAMP_IDLE : OSM_RAMP_HOLD;
            end else begin
               next_ramp_state = OSM_RAMP_STEP;
            end
         end
         OSM_RAMP_HOLD: begin
            next_ramp_state = (target != attn) ? OSM_RAMP_STEP : OSM_RAMP_HOLD;
         end
         default: next_ramp_state = OSM_RAMP_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ramp_state <= OSM_RAMP_IDLE;
      end else begin
         ramp_state <= next_ramp_state;
      end
   end

   // level: immediate when soft ramp is off, else one 1/8 dB step per tick
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         attn <= OSM_ATTN_ZERO;
      end else if (ramp_state == OSM_RAMP_STEP) begin
         if (!soft_en) begin
            attn <= target;
         end else if (step_tick && attn < target) begin
            attn <= attn + OSM_ATTN_ONE;
         end else if (step_tick && attn > target) begin
            attn <= attn - OSM_ATTN_ONE;
         end
      end
   end

   // static mute shows on the pins once fully muted; invalid shows at once
   assign muted = (attn == OSM_ATTN_MUTE);
   assign mute_active = (static_en && hits.static_run && muted) ||
      (invalid_en && hits.invalid);

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         attn_o <= OSM_ATTN_ZERO;
         mute_req_o <= 1'b0;
         mute_control_out_o <= 2'b00;
         muted_d <= 1'b0;
      end else begin
         attn_o <= attn;
         mute_req_o <= static_en && hits.static_run;
         // polarity bit gives the active level of both pins
         mute_control_out_o <= {2{mute_active ~^ mute_pol}};
         muted_d <= muted;
      end
   end

   // mode bits shown to the receiver path
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase_mod_enable_o <= 1'b0;
         phase_mod_clock_select_o <= 1'b0;
      end else begin
         phase_mod_enable_o <= pm_en;
         phase_mod_clock_select_o <= pm_sel;
      end
   end

   // sticky events; a read clears them but a same-cycle event survives
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hits_d <= '0;
      end else begin
         hits_d <= hits;
      end
   end

   always_comb begin
      ev = OSM_ZERO8;
      ev[OSM_ST_STATIC] = static_en && hits.static_run && !hits_d.static_run;
      ev[OSM_ST_INVALID] = invalid_en && hits.invalid && !hits_d.invalid;
      ev[OSM_ST_MUTED] = muted && !muted_d;
   end
   assign rd_status = bus_i.rd && bus_i.addr == OSM_ADDR_STATUS;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status <= OSM_ZERO8;
      end else if (rd_status) begin
         status <= ev;
      end else begin
         status <= status | ev;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status & mask);
      end
   end
endmodule : osm_monitor

// ---- bench/osm_monitor_props.sv ----
// Purpose: port assertions for the stream monitor
// Assumes: helper copies of ctrl, cfg and mask track bus writes
// Notes: bound to osm_monitor below
`timescale 1ns/1ps
module osm_monitor_props
   import osm_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // watched ports
   input wire osm_bus_s bus_i,
   input wire logic [7:0] rdata_o,
   input wire osm_bit_s stream_o,
   input wire logic [OSM_ATTN_W-1:0] attn_o,
   input wire logic mute_req_o,
   input wire logic [1:0] mute_control_out_o,
   input wire logic phase_mod_enable_o,
   input wire logic phase_mod_clock_select_o,
   input wire logic irq_o
);
   logic [7:0] ctrl, cfg, mask;
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl <= OSM_CTRL_RESET;
         cfg <= OSM_CFG_RESET;
         mask <= OSM_ZERO8;
      end else if (bus_i.wr) begin
         if (bus_i.addr == OSM_ADDR_CTRL) ctrl <= bus_i.wdata;
         if (bus_i.addr == OSM_ADDR_CFG) cfg <= bus_i.wdata;
         if (bus_i.addr == OSM_ADDR_MASK) mask <= bus_i.wdata;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_ctrl_wr;
      bus_i.wr && bus_i.addr == OSM_ADDR_CTRL ##2 1'h1;
   endsequence
   // pins checked only once polarity has held still
   sequence s_full_mute;
      (mute_req_o && attn_o == OSM_ATTN_MUTE && $stable(cfg))[*3];
   endsequence
   chk_pm_en_follow: assert property (
      s_ctrl_wr |-> phase_mod_enable_o == $past(bus_i.wdata[OSM_CTRL_PM_EN], 2))
      else $error("phase enable output did not follow write");
   chk_pm_sel_follow: assert property (
      s_ctrl_wr |-> phase_mod_clock_select_o == $past(bus_i.wdata[OSM_CTRL_PM_SEL], 2))
      else $error("clock select output did not follow write");
   chk_rdata_quiet: assert property (!$past(bus_i.rd) |-> rdata_o == OSM_ZERO8)
      else $error("read data outside read slot");
   chk_unmapped_zero: assert property (
      $past(bus_i.rd) && !($past(bus_i.addr) inside {[OSM_ADDR_CTRL:OSM_ADDR_CFG]})
      |-> rdata_o == OSM_ZERO8)
      else $error("unmapped read not zero");
   chk_ctrl_readback: assert property (
      bus_i.rd && bus_i.addr == OSM_ADDR_CTRL |=> rdata_o == ($past(ctrl) & OSM_CTRL_USED))
      else $error("control readback wrong");
   chk_static_off: assert property (
      (!ctrl[OSM_CTRL_STATIC])[*3] |-> !mute_req_o)
      else $error("mute request with static detect off");
   chk_static_mute: assert property (
      !cfg[OSM_CFG_SOFT] && $rose(mute_req_o) |-> ##[0:2] attn_o == OSM_ATTN_MUTE)
      else $error("static mute did not reach full attenuation");
   chk_mute_pins: assert property (
      s_full_mute |-> mute_control_out_o == {2{cfg[OSM_CFG_POL]}})
      else $error("mute pins not at set polarity");
   chk_soft_step: assert property (
      cfg[OSM_CFG_SOFT] && $past(cfg[OSM_CFG_SOFT]) && $changed(attn_o)
      |-> (attn_o - $past(attn_o) == OSM_ATTN_ONE) || ($past(attn_o) - attn_o == OSM_ATTN_ONE))
      else $error("soft ramp step not one unit");
   chk_bit_pulse: assert property (stream_o.valid |=> !stream_o.valid)
      else $error("bit pulse longer than one cycle");
   chk_irq_masked: assert property ((mask == OSM_ZERO8)[*3] |-> !irq_o)
      else $error("interrupt with all sources masked");
endmodule : osm_monitor_props

bind osm_monitor osm_monitor_props u_props (.clock_i(clock_i), .rst_b_i(rst_b_i),
   .bus_i(bus_i), .rdata_o(rdata_o), .stream_o(stream_o), .attn_o(attn_o),
   .mute_req_o(mute_req_o), .mute_control_out_o(mute_control_out_o),
   .phase_mod_enable_o(phase_mod_enable_o),
   .phase_mod_clock_select_o(phase_mod_clock_select_o), .irq_o(irq_o));

// ---- bench/osm_stream_src.sv ----
// Purpose: model of the external one-bit stream source
// Assumes: 400 ns bit clock, running only within frames
// Notes: mode 0 normal, 1 paired 128Fs edges, 2 64Fs with capture on the fall
`timescale 1ns/1ps
module osm_stream_src (
   // link pins
   output logic sck_o,
   output logic data_o
);
   initial begin
      sck_o = 1'h0;
      data_o = 1'h0;
   end
   task automatic send(input logic [63:0] bits, input int n, input int mode);
      for (int i = 0; i < n; i++) begin
         for (int h = 0; h < ((mode == 1) ? 2 : 1); h++) begin
            // second half of a phase pair carries the inverse
            data_o = bits[i] ^ (h == 1);
            #100 sck_o = 1'h1;
            #200 sck_o = 1'h0;
            #100;
         end
      end
      // released line must not look held
      data_o = ~bits[n-1];
   endtask : send
endmodule : osm_stream_src

// ---- bench/osm_monitor_bench.sv ----
// Purpose: self-checking bench for the stream monitor
// Assumes: 20 MHz clock, 400 ns link bit clock from the source model
// Notes: checks settle a fixed pipeline margin after each frame
`timescale 1ns/1ps
module osm_monitor_bench
   import osm_pkg::*;
;
   logic clock_i, rst_b_i, sck, sdata, mute_req, pm_en, pm_sel, irq, last_bit;
   osm_bus_s bus;
   osm_bit_s stream;
   logic [7:0] rdata;
   logic [OSM_ATTN_W-1:0] attn;
   logic [1:0] mute_pins;
   int bad_count, tests_run, cycles, pulses;
   osm_monitor DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .bus_i(bus), .rdata_o(rdata),
      .stream_bit_clock_i(sck), .one_bit_stream_i(sdata), .stream_o(stream), .attn_o(attn),
      .mute_req_o(mute_req), .mute_control_out_o(mute_pins), .phase_mod_enable_o(pm_en),
      .phase_mod_clock_select_o(pm_sel), .irq_o(irq));
   osm_stream_src src (.sck_o(sck), .data_o(sdata));
   initial begin
      clock_i = 1'h0;
      forever #25 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cycles++;
      if (stream.valid === 1'h1) begin
         pulses++;
         last_bit = stream.value;
      end
      // whole plan needs well under this
      if (cycles == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   task automatic check_eq(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check_eq
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
      @(posedge clock_i);
      bus.wr <= 1'h0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_i);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
      @(posedge clock_i);
      bus.rd <= 1'h0;
      #1 d = rdata;
   endtask : reg_rd
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      reg_rd(a, d);
      check_eq($sformatf("register %h", a), exp, d);
   endtask : rd_chk
   // pulse count proves one recovered bit per source bit
   task automatic send_chk(input logic [63:0] bits, input int n, input int mode);
      int p;
      p = pulses;
      src.send(bits, n, mode);
      repeat (12) @(posedge clock_i);
      #1 check_eq("bit pulses", 16'(n), 16'(pulses - p));
      check_eq("last bit", 16'(bits[n-1]), 16'(last_bit));
   endtask : send_chk
   task automatic wait_mute(input logic exp);
      int n;
      n = 0;
      while (mute_req !== exp && n < 40) begin
         @(posedge clock_i);
         n++;
      end
      #1 check_eq("mute_req", exp, mute_req);
   endtask : wait_mute
   task automatic t_reset();
      rd_chk(OSM_ADDR_CTRL, OSM_CTRL_RESET);
      rd_chk(OSM_ADDR_CFG, OSM_CFG_RESET);
      rd_chk(OSM_ADDR_STATUS, OSM_ZERO8);
      rd_chk(OSM_ADDR_MASK, OSM_ZERO8);
      rd_chk(8'h20, OSM_ZERO8);
      check_eq("pm_en", 1'h0, pm_en);
      check_eq("mute pins", 2'h3, mute_pins);
   endtask : t_reset
   task automatic t_regs();
      reg_wr(OSM_ADDR_CTRL, 8'hff);
      reg_wr(8'h20, 8'h5a);
      rd_chk(OSM_ADDR_CTRL, OSM_CTRL_USED);
      check_eq("pm_en", 1'h1, pm_en);
      check_eq("pm_sel", 1'h1, pm_sel);
      rd_chk(8'h20, OSM_ZERO8);
      reg_wr(OSM_ADDR_CTRL, OSM_CTRL_RESET);
      reg_wr(OSM_ADDR_CFG, 8'h00);
      reg_wr(OSM_ADDR_MASK, OSM_ST_USED);
   endtask : t_regs
   task automatic t_static();
      send_chk(64'h0000_0000_0fff_fffe, 28, 0);
      check_eq("mute_req 27 run", 1'h0, mute_req);
      send_chk(64'h0, 28, 0);
      wait_mute(1'h1);
      check_eq("attn", OSM_ATTN_MUTE, attn);
      check_eq("mute pins", 2'h0, mute_pins);
      check_eq("irq", 1'h1, irq);
      rd_chk(OSM_ADDR_STATUS, 8'h05);
      repeat (3) @(posedge clock_i);
      #1 check_eq("irq cleared", 1'h0, irq);
      send_chk(64'haaaa_aaaa_aaaa_aaaa, 28, 0);
      wait_mute(1'h0);
      check_eq("attn", OSM_ATTN_ZERO, attn);
      check_eq("mute pins", 2'h3, mute_pins);
   endtask : t_static
   task automatic t_static_off();
      reg_wr(OSM_ADDR_CTRL, 8'h00);
      send_chk(64'h0, 28, 0);
      check_eq("mute_req off", 1'h0, mute_req);
      check_eq("attn off", OSM_ATTN_ZERO, attn);
   endtask : t_static_off
   task automatic t_invalid();
      logic [7:0] d;
      reg_rd(OSM_ADDR_STATUS, d);
      reg_wr(OSM_ADDR_CTRL, 8'h04);
      reg_wr(OSM_ADDR_CFG, 8'h02);
      send_chk(64'h00fd_fbf7_efdf_bf7e, 56, 0);
      check_eq("attn 24 of 28", OSM_ATTN_ZERO, attn);
      check_eq("mute pins", 2'h0, mute_pins);
      send_chk(64'h0fff_ff8f, 28, 0);
      check_eq("attn 25 of 28", OSM_ATTN_INVALID, attn);
      check_eq("mute pins", 2'h3, mute_pins);
      check_eq("irq", 1'h1, irq);
      rd_chk(OSM_ADDR_STATUS, 8'h02);
   endtask : t_invalid
   task automatic t_pm();
      reg_wr(OSM_ADDR_CFG, 8'h00);
      reg_wr(OSM_ADDR_CTRL, 8'h09);
      send_chk(64'h0, 28, 1);
      wait_mute(1'h1);
      reg_wr(OSM_ADDR_CTRL, 8'h0b);
      send_chk(64'h0fff_ffff, 28, 2);
      wait_mute(1'h1);
      reg_wr(OSM_ADDR_CTRL, OSM_CTRL_RESET);
      send_chk(64'haaaa_aaaa_aaaa_aaaa, 28, 0);
      wait_mute(1'h0);
   endtask : t_pm
   task automatic t_soft();
      reg_wr(OSM_ADDR_CFG, 8'h01);
      send_chk(64'h0, 28, 0);
      wait_mute(1'h1);
      send_chk(64'h0, 64, 0);
      send_chk(64'h0, 64, 0);
      check_eq("attn ramp", 16'h0002, attn);
      check_eq("mute pins", 2'h3, mute_pins);
      reg_wr(OSM_ADDR_CFG, 8'h05);
      send_chk(64'h0, 64, 0);
      send_chk(64'h0, 64, 0);
      check_eq("attn ramp fast", 16'h0003, attn);
   endtask : t_soft
   initial begin
      rst_b_i = 1'h0;
      bus = '0;
      bad_count = 0;
      tests_run = 0;
      cycles = 0;
      pulses = 0;
      repeat (2) @(posedge clock_i);
      rst_b_i <= 1'h1;
      t_reset();
      t_regs();
      t_static();
      t_static_off();
      t_invalid();
      t_pm();
      t_soft();
      tally_and_finish();
   end
endmodule : osm_monitor_bench
